/* File: spp_link.sv */
// Link side shifter clocked on the serial clock
// Assumes the serial clock only toggles while the port is selected
`timescale 1ns/1ps
module spp_link (
  input  wire logic              i_sck,
  input  wire logic              i_sel,
  input  wire logic              i_mosi,
  input  wire logic [7:0]        i_rdata,
  output spp_pkg::spp_instr_t    o_instr,
  output logic                   o_tgl,
  output logic                   o_miso
);
  import spp_pkg::*;
  logic [4:0]  cnt;
  logic [31:0] sr;
  logic [7:0]  tx;
  logic [4:0]  next_cnt;
  logic [31:0] next_sr;
  logic        next_tgl;
  spp_instr_t  next_instr;

  // Rising edge sample, MSB first, four bytes
  always_comb begin
    next_sr    = {sr[30:0], i_mosi};
    next_cnt   = cnt + 5'h01;
    next_tgl   = o_tgl;
    next_instr = o_instr;
    if (cnt == 5'h1F) begin
      next_instr = next_sr;
      next_tgl   = ~o_tgl;
    end
  end

  // Deselect clears the bit counter without any clock
  always_ff @(posedge i_sck or negedge i_sel) begin
    if (!i_sel) begin
      cnt     <= 5'h00;
      sr      <= 32'h0000_0000;
      o_tgl   <= 1'b0;
      o_instr <= '0;
    end else begin
      cnt     <= next_cnt;
      sr      <= next_sr;
      o_tgl   <= next_tgl;
      o_instr <= next_instr;
    end
  end

  // Output on falling edge; byte 3 echoes byte 2, byte 4 returns read data
  always_ff @(negedge i_sck or negedge i_sel) begin
    if (!i_sel) begin
      tx     <= 8'h00;
      o_miso <= 1'b0;
    end else if (cnt == 5'h10) begin
      tx     <= {sr[6:0], 1'b0};
      o_miso <= sr[7];
    end else if (cnt == 5'h18) begin
      tx     <= {i_rdata[6:0], 1'b0};
      o_miso <= i_rdata[7];
    end else begin
      tx     <= {tx[6:0], 1'b0};
      o_miso <= tx[7];
    end
  end
endmodule // spp_link

/* File: spp_pkg.sv */
// Package for the serial programming port: opcodes, sizes, timing counts
// Assumes a 250 MHz system clock
package spp_pkg;
  localparam int          CLK_MHZ        = 250;
  localparam int          FLASH_WAIT_US  = 4500;
  localparam int          EEPROM_WAIT_US = 3600;
  localparam int          ERASE_WAIT_US  = 9000;
  localparam int          FLASH_WAIT_CYC  = FLASH_WAIT_US * CLK_MHZ;
  localparam int          EEPROM_WAIT_CYC = EEPROM_WAIT_US * CLK_MHZ;
  localparam int          ERASE_WAIT_CYC  = ERASE_WAIT_US * CLK_MHZ;
  localparam int          BUSY_W         = 22;
  localparam int          FLASH_WORDS    = 4096;
  localparam int          FLASH_AW       = 12;
  localparam int          PAGE_WORDS     = 64;
  localparam int          PAGE_AW        = 6;
  localparam int          EE_BYTES       = 64;
  localparam int          EE_AW          = 6;
  localparam int          EE_PAGE_AW     = 2;
  localparam logic [7:0]  OP_PREFIX      = 8'hAC;
  localparam logic [7:0]  SUB_ENABLE     = 8'h53;
  localparam logic [7:0]  SUB_ERASE      = 8'h80;
  localparam logic [7:0]  SUB_WR_LOCK    = 8'hE0;
  localparam logic [7:0]  SUB_WR_FUSE_L  = 8'hA0;
  localparam logic [7:0]  SUB_WR_FUSE_H  = 8'hA8;
  localparam logic [7:0]  SUB_WR_FUSE_E  = 8'hA4;
  localparam logic [7:0]  OP_POLL        = 8'hF0;
  localparam logic [7:0]  OP_LD_HI       = 8'h48;
  localparam logic [7:0]  OP_LD_LO       = 8'h40;
  localparam logic [7:0]  OP_LD_EE_PAGE  = 8'hC1;
  localparam logic [7:0]  OP_RD_HI       = 8'h28;
  localparam logic [7:0]  OP_RD_LO       = 8'h20;
  localparam logic [7:0]  OP_RD_EE       = 8'hA0;
  localparam logic [7:0]  OP_RD_LOCK     = 8'h58;
  localparam logic [7:0]  OP_RD_SIG      = 8'h30;
  localparam logic [7:0]  OP_RD_FUSE     = 8'h50;
  localparam logic [7:0]  SUB_HI_FUSE    = 8'h08;
  localparam logic [7:0]  OP_RD_CAL      = 8'h38;
  localparam logic [7:0]  OP_WR_PAGE     = 8'h4C;
  localparam logic [7:0]  OP_WR_EE       = 8'hC0;
  localparam logic [7:0]  OP_WR_EE_PAGE  = 8'hC2;
  localparam logic [7:0]  ERASED         = 8'hFF;
  localparam logic [7:0]  FUSE_RST       = 8'hFF;
  localparam logic [7:0]  CAL_VALUE      = 8'h5A;
  // Signature bytes: arbitrary neutral values
  localparam logic [23:0] SIG_VALUE      = 24'h0102_03;

  // Instruction as handed across from the link domain
  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } spp_instr_t;
endpackage

/* File: spp_port.sv */
// Top of the serial programming port; memories held in flip-flops
// Assumes reset pin high means run mode
`timescale 1ns/1ps
module spp_port (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_sck,
  input  wire logic i_mosi,
  input  wire logic i_reset_pin,
  output logic      o_miso,
  output logic      o_miso_oe,
  output logic      o_prog_mode
);
  import spp_pkg::*;

  spp_instr_t      link_instr;
  logic            link_tgl;
  logic            link_miso;
  logic            tgl_lvl;
  logic            rst_lvl;
  logic            sel;
  logic [7:0]      rdata;

  logic [15:0]     flash [FLASH_WORDS];
  logic [15:0]     pbuf  [PAGE_WORDS];
  logic [7:0]      eep   [EE_BYTES];
  logic [7:0]      ebuf  [4];
  logic [3:0]      eload;
  logic [7:0]      lock_bits;
  logic [7:0]      fuse_l;
  logic [7:0]      fuse_h;
  logic [7:0]      fuse_e;
  logic            enabled;
  logic            tgl_seen;
  logic [BUSY_W-1:0] busy;

  typedef enum {ST_IDLE, ST_ERASE} spp_state_t;
  spp_state_t      state;
  spp_state_t      next_state;
  logic [FLASH_AW-1:0] ecnt;
  logic [FLASH_AW-1:0] next_ecnt;
  logic            next_enabled;
  logic [BUSY_W-1:0] next_busy;
  logic [7:0]      next_lock;
  logic [7:0]      next_fl;
  logic [7:0]      next_fh;
  logic [7:0]      next_fe;
  logic [7:0]      next_rdata;
  logic            next_miso_oe;

  function automatic logic [BUSY_W-1:0] wait_cnt(input int cyc);
    wait_cnt = BUSY_W'(cyc);
  endfunction

  assign sel  = ~i_reset_pin;

  spp_link u_link (
    .i_sck   (i_sck),
    .i_sel   (sel),
    .i_mosi  (i_mosi),
    .i_rdata (rdata),
    .o_instr (link_instr),
    .o_tgl   (link_tgl),
    .o_miso  (link_miso)
  );

  spp_sync u_sync_tgl (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async (link_tgl),
    .o_level (tgl_lvl)
  );

  spp_sync u_sync_rst (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async (i_reset_pin),
    .o_level (rst_lvl)
  );

  logic        new_ins;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [7:0]  b3;
  logic [7:0]  b4;
  logic        is_busy;
  logic [2:0]  settle;
  logic [2:0]  next_settle;
  // Ignore toggle changes until the synchroniser has settled after reset
  assign new_ins = (tgl_lvl != tgl_seen) && (settle == 3'h0);
  assign b1 = link_instr.b1;
  assign b2 = link_instr.b2;
  assign b3 = link_instr.b3;
  assign b4 = link_instr.b4;
  assign is_busy = (busy != '0) || (state == ST_ERASE);

  // Control and register next values
  always_comb begin
    next_state   = state;
    next_ecnt    = ecnt;
    next_enabled = enabled;
    next_busy    = (busy != '0) ? busy - 1'b1 : busy;
    next_lock    = lock_bits;
    next_fl      = fuse_l;
    next_fh      = fuse_h;
    next_fe      = fuse_e;
    next_rdata   = rdata;
    next_miso_oe = !rst_lvl;
    next_settle  = (settle != 3'h0) ? settle - 3'h1 : settle;
    if (rst_lvl) begin
      next_enabled = 1'b0;
    end else if (new_ins && !is_busy) begin
      if (b1 == OP_PREFIX && b2 == SUB_ENABLE) begin
        next_enabled = 1'b1;
      end else if (enabled && b1 == OP_PREFIX) begin
        case (b2)
          SUB_ERASE: begin
            next_state = ST_ERASE;
            next_ecnt  = '0;
            next_busy  = wait_cnt(ERASE_WAIT_CYC);
          end
          SUB_WR_LOCK:   next_lock = b4;
          SUB_WR_FUSE_L: next_fl   = b4;
          SUB_WR_FUSE_H: next_fh   = b4;
          SUB_WR_FUSE_E: next_fe   = b4;
          default: ;
        endcase
      end else if (enabled) begin
        case (b1)
          OP_WR_PAGE:    next_busy = wait_cnt(FLASH_WAIT_CYC);
          OP_WR_EE,
          OP_WR_EE_PAGE: next_busy = wait_cnt(EEPROM_WAIT_CYC);
          default: ;
        endcase
      end
    end
    if (state == ST_ERASE) begin
      next_ecnt = ecnt + 1'b1;
      if (ecnt == FLASH_AW'(FLASH_WORDS - 1)) begin
        next_state = ST_IDLE;
        next_lock  = ERASED;
      end
    end
    // Read data for the fourth byte
    if (new_ins || state == ST_IDLE) begin
      case (b1)
        OP_POLL:    next_rdata = {7'h00, is_busy};
        OP_RD_HI:   next_rdata = flash[{b2[3:0], b3}][15:8];
        OP_RD_LO:   next_rdata = flash[{b2[3:0], b3}][7:0];
        OP_RD_EE:   next_rdata = eep[b3[5:0]];
        OP_RD_LOCK: next_rdata = b2[3] ? fuse_h : lock_bits;
        OP_RD_FUSE: next_rdata = b2[3] ? fuse_e : fuse_l;
        OP_RD_CAL:  next_rdata = CAL_VALUE;
        OP_RD_SIG: begin
          case (b3[1:0])
            2'h0:    next_rdata = SIG_VALUE[23:16];
            2'h1:    next_rdata = SIG_VALUE[15:8];
            default: next_rdata = SIG_VALUE[7:0];
          endcase
        end
        default:    next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state       <= ST_IDLE;
      ecnt        <= '0;
      enabled     <= 1'b0;
      busy        <= '0;
      lock_bits   <= FUSE_RST;
      fuse_l      <= FUSE_RST;
      fuse_h      <= FUSE_RST;
      fuse_e      <= FUSE_RST;
      rdata       <= 8'h00;
      tgl_seen    <= 1'b0;
      settle      <= 3'h7;
      o_miso      <= 1'b0;
      o_miso_oe   <= 1'b0;
      o_prog_mode <= 1'b0;
    end else begin
      state       <= next_state;
      ecnt        <= next_ecnt;
      enabled     <= next_enabled;
      busy        <= next_busy;
      lock_bits   <= next_lock;
      fuse_l      <= next_fl;
      fuse_h      <= next_fh;
      fuse_e      <= next_fe;
      rdata       <= next_rdata;
      tgl_seen    <= tgl_lvl;
      settle      <= next_settle;
      o_miso      <= link_miso;
      o_miso_oe   <= next_miso_oe;
      o_prog_mode <= next_enabled;
    end
  end

  // Memory arrays; flip-flops without reset
  logic do_cmd;
  assign do_cmd = new_ins && enabled && !is_busy && !rst_lvl;
  always_ff @(posedge i_clk) begin
    if (state == ST_ERASE) begin
      flash[ecnt] <= {ERASED, ERASED};
      if (ecnt < FLASH_AW'(EE_BYTES)) begin
        eep[ecnt[EE_AW-1:0]] <= ERASED;
      end
    end else if (do_cmd) begin
      case (b1)
        OP_LD_LO: pbuf[b3[5:0]][7:0]  <= b4;
        OP_LD_HI: pbuf[b3[5:0]][15:8] <= b4;
        OP_WR_PAGE: begin
          for (int i = 0; i < PAGE_WORDS; i++) begin
            flash[{b2[3:0], b3[7:6], 6'(i)}] <= pbuf[i];
          end
        end
        OP_WR_EE: eep[b3[5:0]] <= b4;
        OP_LD_EE_PAGE: ebuf[b3[1:0]] <= b4;
        OP_WR_EE_PAGE: begin
          for (int i = 0; i < 4; i++) begin
            if (eload[i]) begin
              eep[{b3[5:2], 2'(i)}] <= ebuf[i];
            end
          end
        end
        default: ;
      endcase
    end
  end

  // Loaded-location mask for EEPROM page
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      eload <= 4'h0;
    end else if (do_cmd && b1 == OP_LD_EE_PAGE) begin
      eload[b3[1:0]] <= 1'b1;
    end else if (do_cmd && b1 == OP_WR_EE_PAGE) begin
      eload <= 4'h0;
    end
  end

  AST_REJECT: assert property (@(posedge i_clk) disable iff (i_srst)
    (!enabled && new_ins && b1 == OP_PREFIX && b2 == SUB_ERASE)
    |=> state == ST_IDLE) else $error("erase accepted while disabled");
  AST_LEAVE: assert property (@(posedge i_clk) disable iff (i_srst)
    rst_lvl |=> !enabled) else $error("mode kept in run");
  AST_ERASE_END: assert property (@(posedge i_clk) disable iff (i_srst)
    $fell(state == ST_ERASE) |-> lock_bits == ERASED)
    else $error("lock not erased");
  AST_POLL: assert property (@(posedge i_clk) disable iff (i_srst)
    (new_ins && b1 == OP_POLL && state == ST_ERASE) |=> rdata == 8'h01)
    else $error("poll missed busy");
  AST_FUSE: assert property (@(posedge i_clk) disable iff (i_srst)
    (do_cmd && b1 == OP_PREFIX && b2 == SUB_WR_FUSE_H) |=> fuse_h == $past(b4))
    else $error("fuse high not written");
  AST_RDFUSE: assert property (@(posedge i_clk) disable iff (i_srst)
    (new_ins && b1 == OP_RD_LOCK && b2 == SUB_HI_FUSE) |=> rdata == fuse_h)
    else $error("fuse high read wrong");
  AST_BUSY_PG: assert property (@(posedge i_clk) disable iff (i_srst)
    (do_cmd && b1 == OP_WR_PAGE) |=> busy == wait_cnt(FLASH_WAIT_CYC))
    else $error("flash wait not loaded");
  AST_OE: assert property (@(posedge i_clk) disable iff (i_srst)
    rst_lvl |=> !o_miso_oe) else $error("output driven in run");
  COV_EN: cover property (@(posedge i_clk) $rose(enabled));
  COV_ER: cover property (@(posedge i_clk) $fell(state == ST_ERASE));
  COV_PG: cover property (@(posedge i_clk) do_cmd && b1 == OP_WR_PAGE);
endmodule // spp_port

/* File: spp_port_tb_top.sv */
// Self-checking bench for the serial programming port
// Assumes the programmer model drives the link; long waits are not run
`timescale 1ns/1ps
module spp_port_tb_top;
  import spp_pkg::*;
  logic i_clk;
  logic i_srst;
  logic sck;
  logic mosi;
  logic reset_pin;
  logic miso;
  logic miso_oe;
  logic prog_mode;
  int   n_fail;
  int   checks;

  spp_port uut (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_sck       (sck),
    .i_mosi      (mosi),
    .i_reset_pin (reset_pin),
    .o_miso      (miso),
    .o_miso_oe   (miso_oe),
    .o_prog_mode (prog_mode)
  );

  spp_prog prog (
    .i_miso      (miso),
    .o_sck       (sck),
    .o_mosi      (mosi),
    .o_reset_pin (reset_pin)
  );

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Reads answer from the instruction before, so send twice
  task automatic rd2(input logic [31:0] instr, output logic [7:0] d);
    logic [31:0] rx;
    prog.xfer(instr, rx);
    prog.xfer(instr, rx);
    d = rx[7:0];
  endtask

  // Write before enable is dropped
  task automatic t_refuse;
    logic [31:0] rx;
    prog.xfer({OP_PREFIX, SUB_WR_FUSE_L, 8'h00, 8'h00}, rx);
    repeat (10) @(posedge i_clk);
    chk("mode_before", {7'h00, prog_mode}, 8'h00);
  endtask

  // Enable with echo in third byte
  task automatic t_enable;
    logic [31:0] rx;
    prog.xfer({OP_PREFIX, SUB_ENABLE, 8'h00, 8'h00}, rx);
    repeat (10) @(posedge i_clk);
    chk("echo", rx[15:8], SUB_ENABLE);
    chk("mode", {7'h00, prog_mode}, 8'h01);
    chk("oe", {7'h00, miso_oe}, 8'h01);
  endtask

  // Identity, calibration and reset fuse and lock reads
  task automatic t_reads;
    logic [31:0] cmd [8];
    logic [7:0]  exp [8];
    logic [7:0]  d;
    cmd = '{{OP_RD_SIG, 24'h000000}, {OP_RD_SIG, 24'h000100},
            {OP_RD_SIG, 24'h000200}, {OP_RD_CAL, 24'h000000},
            {OP_RD_FUSE, 24'h000000}, {OP_RD_LOCK, SUB_HI_FUSE, 16'h0000},
            {OP_RD_FUSE, SUB_HI_FUSE, 16'h0000}, {OP_RD_LOCK, 24'h000000}};
    exp = '{SIG_VALUE[23:16], SIG_VALUE[15:8], SIG_VALUE[7:0], CAL_VALUE,
            FUSE_RST, FUSE_RST, FUSE_RST, FUSE_RST};
    for (int i = 0; i < 8; i++) begin
      rd2(cmd[i], d);
      chk("read", d, exp[i]);
    end
    rd2({OP_POLL, 24'h000000}, d);
    chk("poll_idle", d & 8'h01, 8'h00);
  endtask

  // Lock and fuse writes, then read back
  task automatic t_fuse_wr;
    logic [7:0]  sub [4];
    logic [15:0] rdc [4];
    logic [7:0]  val [4];
    logic [31:0] rx;
    logic [7:0]  d;
    sub = '{SUB_WR_LOCK, SUB_WR_FUSE_L, SUB_WR_FUSE_H, SUB_WR_FUSE_E};
    rdc = '{{OP_RD_LOCK, 8'h00}, {OP_RD_FUSE, 8'h00},
            {OP_RD_LOCK, SUB_HI_FUSE}, {OP_RD_FUSE, SUB_HI_FUSE}};
    val = '{8'hFC, 8'h62, 8'hDF, 8'hFE};
    for (int i = 0; i < 4; i++) begin
      prog.xfer({OP_PREFIX, sub[i], 8'h00, val[i]}, rx);
    end
    for (int i = 0; i < 4; i++) begin
      rd2({rdc[i], 16'h0000}, d);
      chk("fuse_lock", d, val[i]);
    end
  endtask

  // EEPROM byte write leaves the port busy
  task automatic t_busy;
    logic [31:0] rx;
    logic [7:0]  d;
    prog.xfer({OP_WR_EE, 8'h00, 8'h05, 8'hA5}, rx);
    rd2({OP_POLL, 24'h000000}, d);
    chk("poll_busy", d & 8'h01, 8'h01);
    rd2({OP_RD_EE, 8'h00, 8'h05, 8'h00}, d);
    chk("ee_byte", d, 8'hA5);
  endtask

  // Flash page load, low byte first, commit, read back, then design reset
  task automatic t_flash;
    logic [31:0] rx;
    logic [7:0]  d;
    prog.xfer({OP_LD_LO, 8'h00, 8'h45, 8'h34}, rx);
    prog.xfer({OP_LD_HI, 8'h00, 8'h45, 8'h12}, rx);
    prog.xfer({OP_WR_PAGE, 8'h00, 8'h40, 8'h00}, rx);
    rd2({OP_RD_LO, 8'h00, 8'h45, 8'h00}, d);
    chk("flash_lo", d, 8'h34);
    rd2({OP_RD_HI, 8'h00, 8'h45, 8'h00}, d);
    chk("flash_hi", d, 8'h12);
    rd2({OP_POLL, 24'h000000}, d);
    chk("poll_flash", d & 8'h01, 8'h01);
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (10) @(posedge i_clk);
    chk("mode_srst", {7'h00, prog_mode}, 8'h00);
    t_enable();
  endtask

  // Reset pin high leaves programming mode; no re-entry without enable
  task automatic t_leave;
    logic [31:0] rx;
    prog.set_reset(1'b1);
    chk("mode_left", {7'h00, prog_mode}, 8'h00);
    chk("oe_left", {7'h00, miso_oe}, 8'h00);
    prog.set_reset(1'b0);
    prog.xfer({OP_PREFIX, SUB_WR_LOCK, 8'h00, 8'h00}, rx);
    repeat (10) @(posedge i_clk);
    chk("mode_again", {7'h00, prog_mode}, 8'h00);
  endtask

  initial begin
    #300us;
    n_fail++;
    end_of_test();
  end

  initial begin
    n_fail = 0;
    checks = 0;
    i_srst = 1'b1;
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    // Reset pin pulse puts the link in step
    prog.set_reset(1'b1);
    prog.set_reset(1'b0);
    // Settle before enable; power-up wait scaled down for the run
    repeat (8) @(posedge i_clk);
    t_refuse();
    t_enable();
    t_reads();
    t_fuse_wr();
    t_flash();
    t_busy();
    t_leave();
    end_of_test();
  end
endmodule // spp_port_tb_top

/* File: spp_prog.sv */
// Behavioural model of the external programmer on the serial link
// Assumes the port samples on the rising clock edge and drives on falling
`timescale 1ns/1ps
module spp_prog (
  input  wire logic i_miso,
  output logic      o_sck,
  output logic      o_mosi,
  output logic      o_reset_pin
);
  // Clock and reset pin low at power-up
  initial begin
    o_sck       = 1'b0;
    o_reset_pin = 1'b0;
    o_mosi      = 1'b0;
  end

  // One whole instruction, four bytes MSB first, 32 ns phases
  task automatic xfer(input logic [31:0] instr, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      o_mosi = instr[i];
      #32 o_sck = 1'b1;
      rx[i] = i_miso;
      #32 o_sck = 1'b0;
    end
    // Line released: drive inverse of last bit
    o_mosi = ~instr[0];
    #64;
  endtask

  // Reset pin level change with settling time
  task automatic set_reset(input logic lvl);
    o_reset_pin = lvl;
    #320;
  endtask
endmodule // spp_prog

/* File: spp_sync.sv */
// Three-flop level synchroniser with agreement filter
// Assumes an asynchronous input level
`timescale 1ns/1ps
module spp_sync (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_async,
  output logic      o_level
);
  logic [2:0] sh;
  logic [2:0] next_sh;
  logic       next_level;

  always_comb begin
    next_sh    = {sh[1:0], i_async};
    next_level = (sh[2] == sh[1]) ? sh[1] : o_level;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sh      <= 3'h0;
      o_level <= 1'b0;
    end else begin
      sh      <= next_sh;
      o_level <= next_level;
    end
  end
endmodule // spp_sync
